// ### hw/sdct_map.svh
`ifndef SDCT_MAP_SVH
`define SDCT_MAP_SVH

// speed grade select codes
`define SDCT_GRADE_13E 2'h0
`define SDCT_GRADE_133 2'h1
`define SDCT_GRADE_10E 2'h2

// clock period in ps
`define SDCT_TCK_PS 5000

// minimum intervals in ns, per grade: 13E, 133, 10E
`define SDCT_TRAS_13E 37
`define SDCT_TRAS_133 44
`define SDCT_TRAS_10E 50
`define SDCT_TRC_13E 60
`define SDCT_TRC_133 66
`define SDCT_TRC_10E 70
`define SDCT_TRCD_13E 15
`define SDCT_TRCD_133 20
`define SDCT_TRCD_10E 20
`define SDCT_TRRD_13E 14
`define SDCT_TRRD_133 15
`define SDCT_TRRD_10E 20
`define SDCT_TXSR_13E 67
`define SDCT_TXSR_133 75
`define SDCT_TXSR_10E 80
`define SDCT_TRP_13E 15
`define SDCT_TRP_133 20
`define SDCT_TRP_10E 20
`define SDCT_TRFC_13E 66
`define SDCT_TRFC_133 66
`define SDCT_TRFC_10E 70
// write recovery beyond the extra clock, in ps
`define SDCT_TWRX_13E_PS 7000
`define SDCT_TWRX_133_PS 7500
`define SDCT_TWRX_10E_PS 7000

// maximum row open time, ns
`define SDCT_TRAS_MAX_NS 120000
// power-up pause, us
`define SDCT_TINIT_US 100
// refresh period, ms, and rows per period
`define SDCT_TREF_MS 64
`define SDCT_REF_ROWS 4096

// command codes on {ras_n, cas_n, we_n}
`define SDCT_CMD_NOP 3'h7
`define SDCT_CMD_ACT 3'h3
`define SDCT_CMD_RD 3'h5
`define SDCT_CMD_WR 3'h4
`define SDCT_CMD_PRE 3'h2
`define SDCT_CMD_REF 3'h1

`define SDCT_NBANK 4
`define SDCT_CNT_W 16
`define SDCT_WAKE_REFS 2'h2
`define SDCT_AP_BIT 10

`endif

// ### hw/sdct_pkg.sv
package sdct_pkg;

typedef struct packed {
    logic [1:0] bank;
    logic [11:0] row;
    logic [8:0] col;
    logic write;
    logic auto_pre;
} sdct_req_type;

typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [1:0] ba;
    logic [11:0] addr;
} sdct_cmd_type;

typedef enum logic [6:0] {
    SDCT_ST_POWERUP = 7'h01,
    SDCT_ST_WAKE = 7'h02,
    SDCT_ST_IDLE = 7'h04,
    SDCT_ST_ROWOPEN = 7'h08,
    SDCT_ST_PRECHG = 7'h10,
    SDCT_ST_REFRESH = 7'h20,
    SDCT_ST_SELFREF = 7'h40
} sdct_state_type;

endpackage

// ### hw/sdct_bank_timer.sv
`timescale 1ns/1ps
`include "sdct_map.svh"

// =====================================================
// down counter, per bank or shared: load a cycle count, ready when zero
module sdct_bank_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [`SDCT_CNT_W-1:0] cycles,
    output logic ready
);
    logic [`SDCT_CNT_W-1:0] cnt_q;
    logic [`SDCT_CNT_W-1:0] cnt_d;

    // a larger pending wait is never shortened by a later load
    assign cnt_d = (load && cycles > cnt_q) ? cycles :
                   (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    assign ready = (cnt_q == '0);

    always_ff @(posedge clk) begin
        if (!rstn) cnt_q <= '0;
        else cnt_q <= cnt_d;
    end
endmodule

// ### hw/sdct_host.sv
`timescale 1ns/1ps
`include "sdct_map.svh"

module sdct_host #(
    parameter int unsigned INIT_CYCLES =
        (`SDCT_TINIT_US * 1000000 + `SDCT_TCK_PS - 1) / `SDCT_TCK_PS,
    parameter int unsigned REFI_CYCLES =
        (`SDCT_TREF_MS * 1000000 / `SDCT_REF_ROWS) * 1000 / `SDCT_TCK_PS,
    parameter int unsigned RASMAX_CYCLES =
        (`SDCT_TRAS_MAX_NS * 1000) / `SDCT_TCK_PS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] grade,
    input wire logic req_valid,
    input wire sdct_pkg::sdct_req_type req,
    output logic req_ready,
    input wire logic close_row,
    input wire logic self_ref_req,
    input wire logic rate_gate,
    output logic init_done,
    output logic rd_strobe,
    output sdct_pkg::sdct_cmd_type cmd
);
    localparam int unsigned NB = `SDCT_NBANK;

    // round a ns figure up to whole cycles, never below one
    function automatic logic [`SDCT_CNT_W-1:0] ns2cyc(input int unsigned ns);
        int unsigned c;
        c = (ns * 1000 + `SDCT_TCK_PS - 1) / `SDCT_TCK_PS;
        if (c == 0) c = 1;
        return c[`SDCT_CNT_W-1:0];
    endfunction

    function automatic logic [`SDCT_CNT_W-1:0] pick(input logic [1:0] g,
        input int unsigned a, input int unsigned b, input int unsigned c);
        if (g == `SDCT_GRADE_13E) return ns2cyc(a);
        else if (g == `SDCT_GRADE_133) return ns2cyc(b);
        else return ns2cyc(c);
    endfunction

    // =====================================================
    // grade-dependent cycle counts
    wire logic [`SDCT_CNT_W-1:0] c_ras = pick(grade, `SDCT_TRAS_13E,
        `SDCT_TRAS_133, `SDCT_TRAS_10E);
    wire logic [`SDCT_CNT_W-1:0] c_rc = pick(grade, `SDCT_TRC_13E,
        `SDCT_TRC_133, `SDCT_TRC_10E);
    wire logic [`SDCT_CNT_W-1:0] c_rcd = pick(grade, `SDCT_TRCD_13E,
        `SDCT_TRCD_133, `SDCT_TRCD_10E);
    wire logic [`SDCT_CNT_W-1:0] c_rrd = pick(grade, `SDCT_TRRD_13E,
        `SDCT_TRRD_133, `SDCT_TRRD_10E);
    wire logic [`SDCT_CNT_W-1:0] c_xsr = pick(grade, `SDCT_TXSR_13E,
        `SDCT_TXSR_133, `SDCT_TXSR_10E);
    wire logic [`SDCT_CNT_W-1:0] c_rp = pick(grade, `SDCT_TRP_13E,
        `SDCT_TRP_133, `SDCT_TRP_10E);
    wire logic [`SDCT_CNT_W-1:0] c_rfc = pick(grade, `SDCT_TRFC_13E,
        `SDCT_TRFC_133, `SDCT_TRFC_10E);
    // write recovery: one clock then the ns figure, rounded up
    wire logic [`SDCT_CNT_W-1:0] c_wrx = (grade == `SDCT_GRADE_133) ?
        `SDCT_CNT_W'((`SDCT_TWRX_133_PS + `SDCT_TCK_PS - 1) / `SDCT_TCK_PS) :
        (grade == `SDCT_GRADE_13E) ?
        `SDCT_CNT_W'((`SDCT_TWRX_13E_PS + `SDCT_TCK_PS - 1) / `SDCT_TCK_PS) :
        `SDCT_CNT_W'((`SDCT_TWRX_10E_PS + `SDCT_TCK_PS - 1) / `SDCT_TCK_PS);

    sdct_pkg::sdct_state_type st_q, st_d;
    logic [31:0] wait_q;
    logic [31:0] refi_q;
    logic [31:0] open_q;
    logic [1:0] wake_q;
    logic [1:0] bank_q;
    logic [11:0] row_q;
    logic stale_q;
    logic rd_pipe_q;
    sdct_pkg::sdct_cmd_type cmd_q, cmd_d;

    logic [NB-1:0] act_load, rc_rdy, rcd_rdy, ras_rdy;
    logic rrd_load, rrd_rdy, xsr_load, xsr_rdy;

    // =====================================================
    // per-bank timers, then the shared tRRD and tXSR timers
    for (genvar b = 0; b < NB; b++) begin : g_bank
        sdct_bank_timer u_rc (.clk(clk), .rstn(rstn), .load(act_load[b]),
            .cycles(c_rc), .ready(rc_rdy[b]));
        sdct_bank_timer u_rcd (.clk(clk), .rstn(rstn), .load(act_load[b]),
            .cycles(c_rcd), .ready(rcd_rdy[b]));
        sdct_bank_timer u_ras (.clk(clk), .rstn(rstn), .load(act_load[b]),
            .cycles(c_ras), .ready(ras_rdy[b]));
    end
    sdct_bank_timer u_rrd (.clk(clk), .rstn(rstn), .load(rrd_load),
        .cycles(c_rrd), .ready(rrd_rdy));
    sdct_bank_timer u_xsr (.clk(clk), .rstn(rstn), .load(xsr_load),
        .cycles(c_xsr), .ready(xsr_rdy));

    // =====================================================
    // decode
    wire logic wait_done = (wait_q == 32'h0);
    wire logic refi_due = (refi_q == 32'h0);
    wire logic ras_over = (open_q >= RASMAX_CYCLES);
    wire logic can_act = req_valid && rc_rdy[req.bank] && rrd_rdy && xsr_rdy;
    // a request to another row of the open bank must close it first
    wire logic row_hit = (req.bank == bank_q) && (req.row == row_q);
    wire logic can_rw = req_valid && row_hit && rcd_rdy[bank_q];
    wire logic want_pre = close_row || ras_over || refi_due ||
        self_ref_req || (req_valid && !row_hit);
    wire logic can_pre = ras_rdy[bank_q] && wait_done;

    // single clock, never changed; rate lowered only by cke
    wire logic cke_on = !rate_gate;

    function automatic sdct_pkg::sdct_cmd_type mk(input logic [2:0] c,
        input logic [1:0] ba, input logic [11:0] a, input logic ck);
        sdct_pkg::sdct_cmd_type r;
        r.cs_n = (c == `SDCT_CMD_NOP);
        {r.ras_n, r.cas_n, r.we_n} = c;
        r.cke = ck;
        r.ba = ba;
        r.addr = a;
        return r;
    endfunction

    // =====================================================
    // command sequencer
    always_comb begin
        st_d = st_q;
        cmd_d = mk(`SDCT_CMD_NOP, 2'h0, 12'h0, cke_on);
        req_ready = 1'b0;
        act_load = '0;
        rrd_load = 1'b0;
        xsr_load = 1'b0;
        case (st_q)
            sdct_pkg::SDCT_ST_POWERUP: begin
                // stale_q marks that the pause has been loaded
                if (wait_done && stale_q) st_d = sdct_pkg::SDCT_ST_WAKE;
            end
            sdct_pkg::SDCT_ST_WAKE: begin
                if (wake_q == `SDCT_WAKE_REFS) begin
                    st_d = sdct_pkg::SDCT_ST_IDLE;
                end else if (wait_done) begin
                    cmd_d = mk(`SDCT_CMD_REF, 2'h0, 12'h0, 1'b1);
                end
            end
            sdct_pkg::SDCT_ST_IDLE: begin
                if (stale_q) begin
                    st_d = sdct_pkg::SDCT_ST_WAKE;
                end else if (refi_due) begin
                    cmd_d = mk(`SDCT_CMD_REF, 2'h0, 12'h0, 1'b1);
                    st_d = sdct_pkg::SDCT_ST_REFRESH;
                end else if (self_ref_req) begin
                    cmd_d = mk(`SDCT_CMD_REF, 2'h0, 12'h0, 1'b0);
                    st_d = sdct_pkg::SDCT_ST_SELFREF;
                end else if (can_act && cke_on && wait_done) begin
                    cmd_d = mk(`SDCT_CMD_ACT, req.bank, req.row, 1'b1);
                    act_load[req.bank] = 1'b1;
                    rrd_load = 1'b1;
                    st_d = sdct_pkg::SDCT_ST_ROWOPEN;
                end
            end
            sdct_pkg::SDCT_ST_ROWOPEN: begin
                if (want_pre && can_pre) begin
                    cmd_d = mk(`SDCT_CMD_PRE, bank_q, 12'h0, 1'b1);
                    st_d = sdct_pkg::SDCT_ST_PRECHG;
                end else if (!want_pre && can_rw && cke_on && wait_done) begin
                    req_ready = 1'b1;
                    cmd_d = mk(req.write ? `SDCT_CMD_WR : `SDCT_CMD_RD,
                        bank_q, {1'b0, req.auto_pre, 1'b0, req.col}, 1'b1);
                    if (req.auto_pre) st_d = sdct_pkg::SDCT_ST_PRECHG;
                end
            end
            sdct_pkg::SDCT_ST_PRECHG: begin
                if (wait_done) st_d = sdct_pkg::SDCT_ST_IDLE;
            end
            sdct_pkg::SDCT_ST_REFRESH: begin
                if (wait_done) st_d = sdct_pkg::SDCT_ST_IDLE;
            end
            sdct_pkg::SDCT_ST_SELFREF: begin
                cmd_d = mk(`SDCT_CMD_NOP, 2'h0, 12'h0, self_ref_req);
                if (!self_ref_req) begin
                    xsr_load = 1'b1;
                    st_d = sdct_pkg::SDCT_ST_IDLE;
                end
            end
            default: st_d = sdct_pkg::SDCT_ST_POWERUP;
        endcase
    end

    // wait load on each issued refresh, precharge, read or write; activate loads none
    wire logic is_ref = (st_q != sdct_pkg::SDCT_ST_SELFREF) &&
        !cmd_d.cs_n && ({cmd_d.ras_n, cmd_d.cas_n, cmd_d.we_n} == `SDCT_CMD_REF);
    wire logic is_pre = !cmd_d.cs_n &&
        ({cmd_d.ras_n, cmd_d.cas_n, cmd_d.we_n} == `SDCT_CMD_PRE);
    wire logic ap_wr = req_ready && req.auto_pre && req.write;
    wire logic ap_rd = req_ready && req.auto_pre && !req.write;
    // extra clock of the module register delays the write data too
    wire logic [31:0] wait_d =
        is_ref ? 32'(c_rfc) :
        is_pre ? 32'(c_rp) :
        ap_wr ? 32'(c_rp + c_wrx + 2'h2) :
        ap_rd ? 32'(c_rp + 1'b1) :
        req_ready ? 32'h1 :
        wait_done ? 32'h0 : wait_q - 32'h1;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q <= sdct_pkg::SDCT_ST_POWERUP;
            wait_q <= 32'h0;
            refi_q <= 32'h0;
            open_q <= 32'h0;
            wake_q <= 2'h0;
            bank_q <= 2'h0;
            row_q <= 12'h0;
            stale_q <= 1'b0;
            rd_pipe_q <= 1'b0;
            cmd_q <= mk(`SDCT_CMD_NOP, 2'h0, 12'h0, 1'b0);
        end else begin
            st_q <= st_d;
            cmd_q <= cmd_d;
            // power-up pause loaded once at the reset release
            if (st_q == sdct_pkg::SDCT_ST_POWERUP && wake_q == 2'h0 &&
                refi_q == 32'h0 && wait_q == 32'h0 && !stale_q) begin
                wait_q <= INIT_CYCLES;
                refi_q <= REFI_CYCLES;
                stale_q <= 1'b1;
            end else begin
                wait_q <= wait_d;
                refi_q <= is_ref ? REFI_CYCLES :
                    (refi_q != 32'h0 ? refi_q - 32'h1 : 32'h0);
                if (st_q == sdct_pkg::SDCT_ST_WAKE) stale_q <= 1'b0;
                else if (refi_q == 32'h0 &&
                    st_q == sdct_pkg::SDCT_ST_ROWOPEN) stale_q <= 1'b1;
            end
            if (st_q == sdct_pkg::SDCT_ST_WAKE && is_ref)
                wake_q <= wake_q + 2'h1;
            else if (st_q == sdct_pkg::SDCT_ST_IDLE && stale_q)
                wake_q <= 2'h0;
            if (|act_load) bank_q <= req.bank;
            if (|act_load) row_q <= req.row;
            open_q <= (st_d == sdct_pkg::SDCT_ST_ROWOPEN) ?
                open_q + 32'h1 : 32'h0;
            rd_pipe_q <= req_ready && !req.write;
        end
    end

    assign cmd = cmd_q;
    // read strobe is high with the read command on cmd, one clock after req_ready
    assign rd_strobe = rd_pipe_q;
    assign init_done = (st_q != sdct_pkg::SDCT_ST_POWERUP) &&
        (st_q != sdct_pkg::SDCT_ST_WAKE);

    // =====================================================
    // checks
    a_rcd_gap: assert property (@(posedge clk) disable iff (!rstn)
        req_ready |-> rcd_rdy[bank_q]) else $error("read/write before tRCD");
    a_rrd_gap: assert property (@(posedge clk) disable iff (!rstn)
        rrd_load |-> rrd_rdy) else $error("activate before tRRD");
    a_rc_gap: assert property (@(posedge clk) disable iff (!rstn)
        |act_load |-> (act_load & ~rc_rdy) == '0) else $error("tRC broken");
    a_ras_min: assert property (@(posedge clk) disable iff (!rstn)
        is_pre |-> ras_rdy[bank_q]) else $error("precharge before tRAS");
    a_xsr_gap: assert property (@(posedge clk) disable iff (!rstn)
        |act_load |-> xsr_rdy) else $error("activate before tXSR");
    a_wake_two: assert property (@(posedge clk) disable iff (!rstn)
        $rose(init_done) |-> wake_q == `SDCT_WAKE_REFS)
        else $error("init without two refreshes");
    a_cmd_delay: assert property (@(posedge clk) disable iff (!rstn)
        !cmd_d.cs_n |=> cmd == $past(cmd_d))
        else $error("command not registered");
    a_rate_gate: assert property (@(posedge clk) disable iff (!rstn)
        |act_load |-> !rate_gate) else $error("activate with cke gated");
endmodule

// ### verification/sdct_dev_model.sv
`timescale 1ns/1ps
`include "sdct_map.svh"

// ==========
// device model: input register plus command timing monitor
module sdct_dev_model #(
    parameter int INIT_NS = 250,
    parameter int REF_GAP_NS = 1000
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] grade,
    input wire sdct_pkg::sdct_cmd_type cmd,
    output int viol,
    output int n_ref
);
    sdct_pkg::sdct_cmd_type cq;
    realtime t_act[4];
    realtime t_rdy[4];
    realtime t_any, t_ref, t_sx, t_rst, t_clk, now;
    real tras, trc, trcd, trrd, txsr, trp, twr;
    logic [3:0] opn;
    logic in_sr;
    logic [2:0] op;
    int b;

    function automatic real pick(input int a, input int m, input int c);
        return grade == 2'h0 ? a : (grade == 2'h1 ? m : c);
    endfunction

    // the device sees every command one clock late
    always_ff @(posedge clk) begin
        cq <= cmd;
    end

    always @(posedge clk) begin
        now = $realtime;
        // a stretched clock period is logged as a violation
        if (t_clk > 0 && now - t_clk != `SDCT_TCK_PS / 1000.0) viol++;
        t_clk = now;
        tras = pick(`SDCT_TRAS_13E, `SDCT_TRAS_133, `SDCT_TRAS_10E);
        trc = pick(`SDCT_TRC_13E, `SDCT_TRC_133, `SDCT_TRC_10E);
        trcd = pick(`SDCT_TRCD_13E, `SDCT_TRCD_133, `SDCT_TRCD_10E);
        trrd = pick(`SDCT_TRRD_13E, `SDCT_TRRD_133, `SDCT_TRRD_10E);
        txsr = pick(`SDCT_TXSR_13E, `SDCT_TXSR_133, `SDCT_TXSR_10E);
        trp = pick(`SDCT_TRP_13E, `SDCT_TRP_133, `SDCT_TRP_10E);
        twr = pick(`SDCT_TWRX_13E_PS, `SDCT_TWRX_133_PS,
            `SDCT_TWRX_10E_PS) / 1000.0;
        op = {cq.ras_n, cq.cas_n, cq.we_n};
        b = cq.ba;
        if (!rstn) begin
            t_rst = now;
            t_ref = now;
            n_ref = 0;
            in_sr = 1'b0;
            opn = 4'h0;
            t_sx = -1.0e6;
            t_any = -1.0e6;
            t_act = '{-1.0e6, -1.0e6, -1.0e6, -1.0e6};
            t_rdy = '{0.0, 0.0, 0.0, 0.0};
        end else begin
            if (in_sr && cq.cke) begin
                in_sr = 1'b0;
                t_sx = now;
                t_ref = now;
            end
            if (!cq.cs_n && !cq.cke && op == `SDCT_CMD_REF) begin
                in_sr = 1'b1;
            end else if (!cq.cs_n && cq.cke) begin
                case (op)
                    `SDCT_CMD_ACT: begin
                        if (opn[b] || n_ref < 2) viol++;
                        if (now - t_act[b] < trc) viol++;
                        if (now - t_any < trrd) viol++;
                        if (now - t_sx < txsr) viol++;
                        if (now < t_rdy[b]) viol++;
                        t_act[b] = now;
                        t_any = now;
                        opn[b] = 1'b1;
                    end
                    `SDCT_CMD_RD, `SDCT_CMD_WR: begin
                        if (!opn[b] || now - t_act[b] < trcd) viol++;
                        if (cq.addr[`SDCT_AP_BIT]) begin
                            opn[b] = 1'b0;
                            t_rdy[b] = now + trp;
                            if (op == `SDCT_CMD_WR) begin
                                t_rdy[b] += `SDCT_TCK_PS / 1000.0 + twr;
                            end
                        end
                    end
                    `SDCT_CMD_PRE: begin
                        for (int i = 0; i < 4; i++) begin
                            if ((cq.addr[`SDCT_AP_BIT] || i == b) && opn[i]) begin
                                if (now - t_act[i] < tras) viol++;
                                if (now - t_act[i] > `SDCT_TRAS_MAX_NS) viol++;
                                opn[i] = 1'b0;
                                t_rdy[i] = now + trp;
                            end
                        end
                    end
                    `SDCT_CMD_REF: begin
                        if (opn != 4'h0) viol++;
                        if (n_ref == 0 && now - t_rst < INIT_NS) viol++;
                        if (n_ref >= 2 && now - t_ref > REF_GAP_NS) viol++;
                        n_ref++;
                        t_ref = now;
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// ### verification/sdram_command_timing_bench.sv
`timescale 1ns/1ps
`include "sdct_map.svh"

// ==========
// bench: controller against the device model
module sdram_command_timing_bench;
    localparam int INIT_C = 50;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] grade = 2'h0;
    logic req_valid = 1'b0;
    sdct_pkg::sdct_req_type req = '0;
    logic close_row = 1'b0;
    logic self_ref_req = 1'b0;
    logic rate_gate = 1'b0;
    logic req_ready;
    logic init_done;
    logic rd_strobe;
    sdct_pkg::sdct_cmd_type cmd;
    int viol;
    int n_ref;
    int err_total = 0;
    int n_checks = 0;
    logic [11:0] act_row = '0;

    always #2.5 clk = ~clk;

    // row of the last activate handed to the device
    always @(posedge clk) begin
        if (cmd.cs_n === 1'b0 &&
            {cmd.ras_n, cmd.cas_n, cmd.we_n} === `SDCT_CMD_ACT) begin
            act_row <= cmd.addr;
        end
    end

    sdct_host #(.INIT_CYCLES(INIT_C), .REFI_CYCLES(40),
        .RASMAX_CYCLES(100)) uut (.clk, .rstn, .grade, .req_valid, .req,
        .req_ready, .close_row, .self_ref_req, .rate_gate, .init_done,
        .rd_strobe, .cmd);
    sdct_dev_model #(.INIT_NS(INIT_C * 5), .REF_GAP_NS(1000)) dev (.clk,
        .rstn, .grade, .cmd, .viol, .n_ref);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wait_op(input logic [2:0] op, input logic ck);
        int n;
        n = 0;
        while (n < 300 && !(cmd.cs_n === 1'b0 && cmd.cke === ck &&
            {cmd.ras_n, cmd.cas_n, cmd.we_n} === op)) begin
            @(negedge clk);
            n++;
        end
        chk(n < 300, 1);
    endtask

    task automatic t_init(input logic [1:0] g);
        int n;
        n = 0;
        @(posedge clk);
        grade <= g;
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        while (init_done !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        // the model counts a refresh two clocks after it is issued
        repeat (2) @(negedge clk);
        chk(n_ref, 2);
        chk(n >= INIT_C, 1);
    endtask

    task automatic acc(input logic [1:0] b, input logic [11:0] r,
        input logic [8:0] c, input logic w, input logic ap);
        int n;
        n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{bank: b, row: r, col: c, write: w, auto_pre: ap};
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(req_ready, 1);
        chk(act_row, r);
        @(posedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
        chk({cmd.ras_n, cmd.cas_n, cmd.we_n},
            w ? `SDCT_CMD_WR : `SDCT_CMD_RD);
        chk({cmd.ba, cmd.addr[`SDCT_AP_BIT], cmd.addr[8:0]}, {b, ap, c});
        chk(rd_strobe, !w);
    endtask

    // back-to-back same row, bank switch, auto-precharge write then reopen
    task automatic t_rows;
        acc(2'h0, 12'h001, 9'h005, 1'b0, 1'b0);
        acc(2'h0, 12'h001, 9'h006, 1'b1, 1'b0);
        acc(2'h1, 12'h002, 9'h007, 1'b0, 1'b0);
        acc(2'h1, 12'h002, 9'h008, 1'b1, 1'b1);
        acc(2'h1, 12'h003, 9'h1FF, 1'b0, 1'b0);
        acc(2'h1, 12'h00A, 9'h020, 1'b1, 1'b0);
        @(posedge clk);
        close_row <= 1'b1;
        wait_op(`SDCT_CMD_PRE, 1'b1);
        @(posedge clk);
        close_row <= 1'b0;
        chk(viol, 0);
    endtask

    task automatic t_selfref;
        @(posedge clk);
        self_ref_req <= 1'b1;
        wait_op(`SDCT_CMD_REF, 1'b0);
        repeat (20) @(posedge clk);
        self_ref_req <= 1'b0;
        acc(2'h3, 12'h004, 9'h001, 1'b0, 1'b0);
        chk(viol, 0);
    endtask

    // a request held while clock enable is gated must not be taken
    task automatic t_gate;
        int cnt;
        int hi;
        cnt = 0;
        hi = 0;
        @(posedge clk);
        rate_gate <= 1'b1;
        req_valid <= 1'b1;
        req <= '{bank: 2'h2, row: 12'h005, col: 9'h002, write: 1'b1,
            auto_pre: 1'b0};
        repeat (3) @(posedge clk);
        repeat (20) begin
            @(negedge clk);
            if (req_ready !== 1'b0) cnt++;
            // refresh may still go out with cke high; idle cycles may not
            if (cmd.cs_n === 1'b1 && cmd.cke !== 1'b0) hi++;
        end
        chk(cnt, 0);
        chk(hi, 0);
        @(posedge clk);
        rate_gate <= 1'b0;
        acc(2'h2, 12'h005, 9'h002, 1'b1, 1'b0);
    endtask

    // row left open far past the refresh period
    task automatic t_long;
        int r0;
        acc(2'h0, 12'h006, 9'h010, 1'b0, 1'b0);
        r0 = n_ref;
        repeat (300) @(posedge clk);
        chk(n_ref > r0 + 2, 1);
        acc(2'h0, 12'h006, 9'h011, 1'b1, 1'b0);
        chk(viol, 0);
    endtask

    initial begin
        for (int g = 0; g < 3; g++) begin
            t_init(g[1:0]);
            t_rows();
        end
        t_selfref();
        t_gate();
        t_long();
        repeat (3) @(posedge clk);
        chk(viol, 0);
        give_verdict();
    end

    // the whole run needs well under 10000 cycles
    initial begin
        #200000;
        err_total++;
        give_verdict();
    end
endmodule
